//--- rtl/mdfm_top.sv
// Motor driver fault manager: protection responses and power modes
// Summary of operation
// - Phase overcurrent counts only after deglitch time
// - Pin variant: fixed deglitch, latched, pin level
// - Register variant: level, deglitch, four actions
// - Latched: FETs off until clear and quiet
// - Retry: FETs off, recover after retry interval
// - Flags survive retry until cleared
// - Report only: FETs run, error low, latched
// - Disabled action: nothing happens
// - Buck overcurrent: buck off, auto clear
// - Warning sets flags; error only if enabled
// - Warning flag needs clear and cool die
// - Two independent thermal shutdown inputs
// - FET-area shutdown: FETs, pump off, auto resume
// - Die shutdown also turns buck off
// - Sleep pin low: sleep after delay
// - Sleep pin high wakes; host waits wake
// - Error output low during power transitions
// - Operating mode when pin high, supply good
// - Clear bit or reset pulse clears latch
// - Long low sleeps; short pulse keeps settings
// - Disable pin kills FETs, hides driver faults
`timescale 1ns/10ps
`default_nettype none
`include "mdfm_defs.svh"
module mdfm_top #(
    parameter int RETRY_CYC    = `MDFM_US_UP(`MDFM_RETRY_US),
    parameter int BK_RETRY_CYC = `MDFM_US_UP(`MDFM_BK_RETRY_US),
    parameter int WAKE_CYC     = `MDFM_US_UP(`MDFM_WAKE_US)
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire mdfm_pkg::mdfm_cfg_t cfg,
    input  wire logic              clear_errors_wr,
    input  wire logic              clear_errors_cmd,
    input  wire logic [5:0]        phase_oc_raw,
    input  wire logic              buck_oc_raw,
    input  wire logic              temp_warn_raw,
    input  wire logic              tsd_fet_raw,
    input  wire logic              tsd_die_raw,
    input  wire logic              supply_ok,
    input  wire logic              low_power_ctrl_n,
    input  wire logic              output_disable_pin,
    input  wire logic              overcurrent_slew_pin,
    input  wire logic [2:0]        high_side_inputs,
    input  wire logic [2:0]        low_side_inputs,
    output var  logic              error_out_n,
    output var  logic [2:0]        gate_hs,
    output var  logic [2:0]        gate_ls,
    output var  logic              charge_pump_en,
    output var  logic              buck_en,
    output var  logic              avdd_en,
    output var  logic              sense_amp_en,
    output var  logic              serial_en,
    output var  logic [1:0]        overcurrent_level_out,
    output var  logic              clear_errors_rd,
    output var  mdfm_pkg::mdfm_flags_t flags,
    output var  logic [7:0]        chip_status_reg
);
    import mdfm_pkg::*;

    localparam int SLEEP_CYC = `MDFM_US_UP(`MDFM_SLEEP_US);
    localparam int RST_CYC   = `MDFM_US_DN(`MDFM_RST_US);
    localparam logic [7:0] BK_DEG_CYC = 8'(`MDFM_NS_UP(`MDFM_BK_DEG_NS));

    function automatic logic [7:0] deg_cyc(input logic hw,
                                           input logic [1:0] sel);
        logic [7:0] c;
        c = 8'(`MDFM_NS_UP(`MDFM_OC_DEG_HW_NS));
        if (!hw) begin
            unique case (sel)
                2'h0: c = 8'(`MDFM_NS_UP(`MDFM_OC_DEG0_NS));
                2'h1: c = 8'(`MDFM_NS_UP(`MDFM_OC_DEG1_NS));
                2'h2: c = 8'(`MDFM_NS_UP(`MDFM_OC_DEG2_NS));
                2'h3: c = 8'(`MDFM_NS_UP(`MDFM_OC_DEG3_NS));
            endcase
        end
        return c;
    endfunction

    function automatic logic [1:0] oc_mode(input logic hw,
                                           input logic [1:0] sel);
        return hw ? `MDFM_OC_LATCH : sel;
    endfunction

    logic [7:0]  pin_s1_reg;
    logic [7:0]  pin_s2_reg;
    logic        drv_off;
    logic [2:0]  hs_in;
    logic [2:0]  ls_in;
    logic        slew_in;
    logic [9:0]  det_raw;
    logic [9:0]  det;
    logic [79:0] det_thr;
    logic [1:0]  mode;
    logic        active;
    logic        busy;
    logic        asleep;
    logic        reset_pulse;
    logic        clr_bit_reg;
    logic        clr_all;
    logic        oc_cond;
    logic        oc_prev_reg;
    logic        oc_rise;
    logic        oc_evt;
    logic        clr_oc;
    logic        oc_latch_reg;
    logic        oc_retry_reg;
    logic        oc_rep_reg;
    logic        buck_prev_reg;
    logic        buck_evt;
    logic        buck_retry_reg;
    logic        buck_done;
    logic        warn_pend_reg;
    logic        tsd_any;
    logic        fet_en;
    logic [`MDFM_TMR_W-1:0] oc_cnt_reg;
    logic [`MDFM_TMR_W-1:0] bk_cnt_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_s1_reg <= 8'h00;
            pin_s2_reg <= 8'h00;
        end else begin
            pin_s1_reg <= {output_disable_pin, overcurrent_slew_pin,
                           high_side_inputs, low_side_inputs};
            pin_s2_reg <= pin_s1_reg;
        end
    end
    assign drv_off = pin_s2_reg[7];
    assign slew_in = pin_s2_reg[6];
    assign hs_in   = pin_s2_reg[5:3];
    assign ls_in   = pin_s2_reg[2:0];

    mdfm_sleep_ctrl #(
        .SLEEP_CYC (SLEEP_CYC),
        .WAKE_CYC  (WAKE_CYC),
        .RST_CYC   (RST_CYC)
    ) u_sleep (
        .clk              (clk),
        .reset_n          (reset_n),
        .low_power_ctrl_n (low_power_ctrl_n),
        .supply_ok        (supply_ok),
        .active           (active),
        .busy             (busy),
        .asleep           (asleep),
        .reset_pulse      (reset_pulse)
    );

    // Detectors: 0-5 phases, 6 buck, 7 warning, 8 FET shutdown, 9 die
    assign det_raw = {tsd_die_raw, tsd_fet_raw, temp_warn_raw,
                      buck_oc_raw, phase_oc_raw};
    assign det_thr = {{3{`MDFM_TEMP_DEG_CYC}}, BK_DEG_CYC,
        {6{deg_cyc(cfg.hw_variant, cfg.overcurrent_deglitch_sel)}}};
    genvar gi;
    generate
        for (gi = 0; gi < 10; gi++) begin : g_det
            mdfm_deglitch u_deg (
                .clk     (clk),
                .reset_n (reset_n),
                .raw     (det_raw[gi]),
                .thr_cyc (det_thr[gi*8 +: 8]),
                .level   (det[gi])
            );
        end
    endgenerate

    assign mode    = oc_mode(cfg.hw_variant,
                             cfg.overcurrent_action_sel);
    assign tsd_any = det[8] | det[9];
    assign oc_cond = |det[5:0] & active & !drv_off;
    assign oc_rise = oc_cond & !oc_prev_reg;
    assign oc_evt  = oc_rise & (mode != `MDFM_OC_OFF);
    assign clr_all = clr_bit_reg | reset_pulse | asleep;
    assign clr_oc  = clr_all & (!oc_cond | asleep);
    assign buck_evt  = det[6] & !buck_prev_reg & active;
    assign buck_done = buck_retry_reg &&
                       bk_cnt_reg == `MDFM_TMR_W'(BK_RETRY_CYC - 1);

    // Clear command strobe lasts one cycle and reads back zero after
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) clr_bit_reg <= 1'b0;
        else clr_bit_reg <= clear_errors_wr & clear_errors_cmd;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) clear_errors_rd <= 1'b0;
        else clear_errors_rd <= clear_errors_wr & clear_errors_cmd;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            oc_prev_reg   <= 1'b0;
            buck_prev_reg <= 1'b0;
        end else begin
            oc_prev_reg   <= oc_cond;
            buck_prev_reg <= det[6] & active;
        end
    end

    // Phase overcurrent responses per action mode
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            oc_latch_reg <= 1'b0;
            oc_rep_reg   <= 1'b0;
        end else begin
            oc_latch_reg <= (oc_evt && mode == `MDFM_OC_LATCH) ||
                            (oc_latch_reg && !clr_oc);
            oc_rep_reg   <= (oc_evt && mode == `MDFM_OC_REPORT) ||
                            (oc_rep_reg && !clr_oc);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            oc_retry_reg <= 1'b0;
            oc_cnt_reg   <= '0;
        end else if (oc_evt && mode == `MDFM_OC_RETRY) begin
            oc_retry_reg <= 1'b1;
            oc_cnt_reg   <= '0;
        end else if (oc_retry_reg) begin
            oc_cnt_reg <= oc_cnt_reg + 1'b1;
            if (oc_cnt_reg == `MDFM_TMR_W'(RETRY_CYC - 1) || asleep)
                oc_retry_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            buck_retry_reg <= 1'b0;
            bk_cnt_reg     <= '0;
        end else if (buck_evt) begin
            buck_retry_reg <= 1'b1;
            bk_cnt_reg     <= '0;
        end else if (buck_retry_reg) begin
            bk_cnt_reg <= bk_cnt_reg + 1'b1;
            if (buck_done || asleep) buck_retry_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) warn_pend_reg <= 1'b0;
        else warn_pend_reg <= (clr_all | warn_pend_reg) &
                              flags.temp_warning_flag & det[7];
    end

    // Sticky status flags, buck flags auto clear at retry end; a new event wins over a clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flags <= '0;
        end else begin
            flags.overcurrent_flag <= oc_evt |
                (flags.overcurrent_flag & !clr_oc);
            flags.fet_oc <= (oc_evt ? det[5:0] : 6'h00) |
                (flags.fet_oc & {6{!clr_oc}});
            flags.buck_error_flag <= buck_evt |
                (flags.buck_error_flag & !buck_done & !asleep);
            flags.buck_overcurrent_flag <= buck_evt |
                (flags.buck_overcurrent_flag & !buck_done & !asleep);
            flags.temp_warning_flag <= det[7] |
                (flags.temp_warning_flag &
                 !(clr_all | warn_pend_reg));
            flags.thermal_shutdown_flag <= tsd_any |
                (flags.thermal_shutdown_flag & !clr_all);
            flags.overtemp_flag <= det[7] | tsd_any |
                (flags.overtemp_flag & !clr_all);
            flags.fault <= oc_evt | buck_evt | tsd_any |
                (flags.fault & !(clr_oc | (buck_done &&
                 !flags.overcurrent_flag &&
                 !flags.thermal_shutdown_flag)));
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            chip_status_reg <= `MDFM_ST_RST;
        end else begin
            chip_status_reg <= `MDFM_ST_RST;
            chip_status_reg[`MDFM_ST_FAULT_BIT] <= flags.fault;
            chip_status_reg[`MDFM_ST_OT_BIT]    <= flags.overtemp_flag;
            chip_status_reg[`MDFM_ST_OCP_BIT]   <= flags.overcurrent_flag;
            chip_status_reg[`MDFM_ST_BK_BIT]    <= flags.buck_error_flag;
        end
    end

    assign fet_en = active & !drv_off & !oc_latch_reg & !oc_retry_reg &
                    !tsd_any;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gate_hs <= 3'h0;
            gate_ls <= 3'h0;
        end else begin
            gate_hs <= fet_en ? hs_in : 3'h0;
            gate_ls <= fet_en ? ls_in : 3'h0;
        end
    end

    // Block enables per power mode and thermal state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            charge_pump_en <= 1'b0;
            buck_en        <= 1'b0;
            avdd_en        <= 1'b0;
            sense_amp_en   <= 1'b0;
            serial_en      <= 1'b0;
        end else begin
            charge_pump_en <= active & !tsd_any;
            buck_en        <= active & !det[9] & !buck_retry_reg;
            avdd_en        <= active;
            sense_amp_en   <= active;
            serial_en      <= active;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) overcurrent_level_out <= 2'h0;
        else overcurrent_level_out <= cfg.hw_variant ?
            {1'b0, slew_in} : cfg.overcurrent_level_sel;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            error_out_n <= 1'b0;
        end else begin
            error_out_n <= !(oc_latch_reg | oc_retry_reg | oc_rep_reg |
                buck_retry_reg | tsd_any | busy |
                (cfg.warning_report_en & det[7]));
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    latch_fets_off_a: assert property (
        oc_evt && mode == `MDFM_OC_LATCH |-> ##2 (gate_hs == 3'h0 &&
        gate_ls == 3'h0 && !error_out_n))
        else $error("latched overcurrent left FETs on");
    error_on_oc_a: assert property (
        oc_evt |-> ##2 !error_out_n)
        else $error("overcurrent did not pull error low");
    oc_disabled_a: assert property (
        oc_rise && mode == `MDFM_OC_OFF && !flags.overcurrent_flag
        |=> !flags.overcurrent_flag)
        else $error("disabled overcurrent set a flag");
    retry_keeps_flag_a: assert property (
        flags.overcurrent_flag && !clr_oc |=> flags.overcurrent_flag)
        else $error("overcurrent flag dropped without a clear");
    buck_off_a: assert property (
        buck_evt |-> ##2 (!buck_en && flags.buck_error_flag))
        else $error("buck overcurrent left buck running");
    tsd_pump_off_a: assert property (
        tsd_any |=> (!charge_pump_en && flags.thermal_shutdown_flag))
        else $error("thermal shutdown left charge pump on");
    disable_pin_a: assert property (
        drv_off |=> (gate_hs == 3'h0 && gate_ls == 3'h0))
        else $error("disable pin did not stop FETs");
    warn_hold_a: assert property (
        flags.temp_warning_flag && det[7] |=> flags.temp_warning_flag)
        else $error("warning flag cleared while still hot");
    sleep_off_a: assert property (
        asleep |=> (!serial_en && !buck_en && gate_hs == 3'h0))
        else $error("blocks still enabled in sleep");

    cov_latch_c: cover property (oc_evt && mode == `MDFM_OC_LATCH);
    cov_retry_c: cover property ($fell(oc_retry_reg));
    cov_pulse_c: cover property (reset_pulse && flags.fault);
    cov_buck_c:  cover property (buck_done);
endmodule
`default_nettype wire

//--- pkg/mdfm_defs.svh
// Timing, code and bit-position constants of the fault manager
`ifndef MDFM_DEFS_SVH
`define MDFM_DEFS_SVH
`define MDFM_CLK_MHZ        25
`define MDFM_NS_UP(ns)      (((ns) * `MDFM_CLK_MHZ + 999) / 1000)
`define MDFM_US_UP(us)      ((us) * `MDFM_CLK_MHZ)
`define MDFM_US_DN(us)      ((us) * `MDFM_CLK_MHZ)
`define MDFM_OC_DEG_HW_NS   600
`define MDFM_OC_DEG0_NS     200
`define MDFM_OC_DEG1_NS     600
`define MDFM_OC_DEG2_NS     1200
`define MDFM_OC_DEG3_NS     1600
`define MDFM_BK_DEG_NS      1000
`define MDFM_TEMP_DEG_CYC   8'h01
`define MDFM_RETRY_US       5000
`define MDFM_BK_RETRY_US    5000
`define MDFM_SLEEP_US       120
`define MDFM_WAKE_US        1000
`define MDFM_RST_US         20
`define MDFM_TMR_W          18
`define MDFM_OC_LATCH       2'h0
`define MDFM_OC_RETRY       2'h1
`define MDFM_OC_REPORT      2'h2
`define MDFM_OC_OFF         2'h3
`define MDFM_ST_FAULT_BIT   0
`define MDFM_ST_OT_BIT      1
`define MDFM_ST_OCP_BIT     4
`define MDFM_ST_BK_BIT      6
`define MDFM_ST_RST         8'h00
`endif

//--- pkg/mdfm_pkg.sv
// Types shared by the fault manager modules
package mdfm_pkg;
    typedef struct packed {
        logic       hw_variant;
        logic [1:0] overcurrent_action_sel;
        logic [1:0] overcurrent_level_sel;
        logic [1:0] overcurrent_deglitch_sel;
        logic       warning_report_en;
    } mdfm_cfg_t;

    typedef struct packed {
        logic       fault;
        logic       overtemp_flag;
        logic       overcurrent_flag;
        logic [5:0] fet_oc;
        logic       buck_error_flag;
        logic       buck_overcurrent_flag;
        logic       temp_warning_flag;
        logic       thermal_shutdown_flag;
    } mdfm_flags_t;

    typedef enum logic [4:0] {
        PW_SLEEP  = 5'b00001,
        PW_WAKE   = 5'b00010,
        PW_ACTIVE = 5'b00100,
        PW_LOWCHK = 5'b01000,
        PW_ENTER  = 5'b10000
    } mdfm_pwr_t;
endpackage

//--- rtl/mdfm_deglitch.sv
// Synchroniser and deglitch filter for one detector input
`timescale 1ns/10ps
`default_nettype none
module mdfm_deglitch (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       raw,
    input  wire logic [7:0] thr_cyc,
    output var  logic       level
);
    logic       s1_reg;
    logic       s2_reg;
    logic [7:0] cnt_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
        end else begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
        end
    end

    // Level rises only after the input stays high past the threshold
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg <= 8'h00;
            level   <= 1'b0;
        end else if (!s2_reg) begin
            cnt_reg <= 8'h00;
            level   <= 1'b0;
        end else if (cnt_reg >= thr_cyc) begin
            level   <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
endmodule
`default_nettype wire

//--- rtl/mdfm_sleep_ctrl.sv
// Sleep, wake and reset-pulse sequencer driven by the sleep pin
`timescale 1ns/10ps
`default_nettype none
`include "mdfm_defs.svh"
module mdfm_sleep_ctrl #(
    parameter int SLEEP_CYC = 3000,
    parameter int WAKE_CYC  = 25000,
    parameter int RST_CYC   = 500
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic low_power_ctrl_n,
    input  wire logic supply_ok,
    output var  logic active,
    output var  logic busy,
    output var  logic asleep,
    output var  logic reset_pulse
);
    import mdfm_pkg::*;
    mdfm_pwr_t               st_reg;
    logic [`MDFM_TMR_W-1:0]  cnt_reg;
    logic [1:0]              pin_s1_reg;
    logic [1:0]              pin_s2_reg;
    logic                    pin;
    logic                    ok;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_s1_reg <= 2'h0;
            pin_s2_reg <= 2'h0;
        end else begin
            pin_s1_reg <= {low_power_ctrl_n, supply_ok};
            pin_s2_reg <= pin_s1_reg;
        end
    end
    assign pin = pin_s2_reg[1];
    assign ok  = pin_s2_reg[0];

    // Short low: reset pulse; long low: full sleep entry
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg      <= PW_SLEEP;
            cnt_reg     <= '0;
            reset_pulse <= 1'b0;
        end else begin
            reset_pulse <= 1'b0;
            cnt_reg     <= cnt_reg + 1'b1;
            unique case (st_reg)
                PW_SLEEP: begin
                    cnt_reg <= '0;
                    if (pin && ok) st_reg <= PW_WAKE;
                end
                PW_WAKE: begin
                    if (!pin || !ok) st_reg <= PW_SLEEP;
                    else if (cnt_reg == `MDFM_TMR_W'(WAKE_CYC - 1))
                        st_reg <= PW_ACTIVE;
                end
                PW_ACTIVE: begin
                    cnt_reg <= '0;
                    if (!ok) st_reg <= PW_SLEEP;
                    else if (!pin) st_reg <= PW_LOWCHK;
                end
                PW_LOWCHK: begin
                    if (pin) begin
                        st_reg      <= PW_ACTIVE;
                        reset_pulse <= 1'b1;
                    end else if (cnt_reg == `MDFM_TMR_W'(RST_CYC - 1)) begin
                        st_reg <= PW_ENTER;
                    end
                end
                PW_ENTER: begin
                    if (cnt_reg == `MDFM_TMR_W'(SLEEP_CYC - 1))
                        st_reg <= PW_SLEEP;
                end
            endcase
        end
    end

    assign active = (st_reg == PW_ACTIVE) || (st_reg == PW_LOWCHK) ||
                    (st_reg == PW_ENTER);
    assign busy   = (st_reg == PW_WAKE) || (st_reg == PW_ENTER);
    assign asleep = (st_reg == PW_SLEEP);
endmodule
`default_nettype wire

//--- tb/mdfm_host_model.sv
// Host controller model: sleep pin, disable pin, gate requests
`timescale 1ns/10ps
`default_nettype none
module mdfm_host_model #(
    parameter int WAKE_WAIT = 20,
    parameter int PULSE_LEN = 20
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       sleep_req,
    input  wire logic       pulse_req,
    input  wire logic       off_req,
    output var  logic       low_power_ctrl_n,
    output var  logic       output_disable_pin,
    output var  logic       ready,
    output var  logic [2:0] high_side_inputs,
    output var  logic [2:0] low_side_inputs
);
    int wait_cnt = 0;
    int low_cnt = 0;
    always @(negedge clk or negedge reset_n) begin
        if (!reset_n || sleep_req)
            wait_cnt <= 0;
        else if (wait_cnt < WAKE_WAIT)
            wait_cnt <= wait_cnt + 1;
        if (pulse_req)
            low_cnt <= PULSE_LEN;
        else if (low_cnt > 0)
            low_cnt <= low_cnt - 1;
    end
    assign ready = wait_cnt >= WAKE_WAIT;
    assign low_power_ctrl_n = !sleep_req && low_cnt == 0;
    assign output_disable_pin = off_req;
    assign high_side_inputs = ready ? 3'b101 : 3'b000;
    assign low_side_inputs = ready ? 3'b010 : 3'b000;
endmodule
`default_nettype wire

//--- tb/mdfm_top_test.sv
// Self-checking bench for the motor driver fault manager
`timescale 1ns/10ps
`default_nettype none
module mdfm_top_test;
    import mdfm_pkg::*;
    logic        clk = 1'b0, reset_n = 1'b0, clr_wr = 1'b0, slew = 1'b0;
    logic        bk_raw = 1'b0, warn_raw = 1'b0, tf_raw = 1'b0, td_raw = 1'b0;
    logic        sleep_req = 1'b0, pulse_req = 1'b0, off_req = 1'b0;
    logic        sup = 1'b1;
    logic        lp_n, dis, ready, err_n, cp, bk, av, sa, se, rd;
    logic [5:0]  oc_raw = 6'h00;
    logic [2:0]  hs_in, ls_in, g_hs, g_ls;
    logic [1:0]  lvl;
    logic [7:0]  st;
    mdfm_cfg_t   cfg = '0;
    mdfm_flags_t fl;
    int          mismatches = 0, num_checks = 0, cycles = 0;
    mdfm_top #(.RETRY_CYC(20), .BK_RETRY_CYC(20), .WAKE_CYC(10)) DUT (
        .clk(clk), .reset_n(reset_n), .cfg(cfg), .clear_errors_wr(clr_wr),
        .clear_errors_cmd(clr_wr), .phase_oc_raw(oc_raw), .buck_oc_raw(bk_raw),
        .temp_warn_raw(warn_raw), .tsd_fet_raw(tf_raw), .tsd_die_raw(td_raw),
        .supply_ok(sup), .low_power_ctrl_n(lp_n), .output_disable_pin(dis),
        .overcurrent_slew_pin(slew), .high_side_inputs(hs_in),
        .low_side_inputs(ls_in), .error_out_n(err_n), .gate_hs(g_hs),
        .gate_ls(g_ls), .charge_pump_en(cp), .buck_en(bk), .avdd_en(av),
        .sense_amp_en(sa), .serial_en(se), .overcurrent_level_out(lvl),
        .clear_errors_rd(rd), .flags(fl), .chip_status_reg(st));
    mdfm_host_model HOST (
        .clk(clk), .reset_n(reset_n), .sleep_req(sleep_req),
        .pulse_req(pulse_req), .off_req(off_req), .low_power_ctrl_n(lp_n),
        .output_disable_pin(dis), .ready(ready), .high_side_inputs(hs_in),
        .low_side_inputs(ls_in));
    always #20 clk = ~clk;
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task chk(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            report_and_stop;
        end
    end
    task clr;
        int n;
        clr_wr = 1'b1;
        cyc(1);
        clr_wr = 1'b0;
        n = int'(rd === 1'b1);
        repeat (3) begin
            cyc(1);
            n += int'(rd === 1'b1);
        end
        chk(n == 1 && rd === 1'b0, "clear strobe");
    endtask
    task wake;
        repeat (60) if (ready !== 1'b1) cyc(1);
        cyc(2);
        chk({err_n, cp, bk, av, sa, se} === 6'h3f, "awake");
    endtask
    task oc_mode(input logic [1:0] m);
        cfg.overcurrent_action_sel = m;
        oc_raw = 6'h01;
        cyc(14);
        chk(err_n === (m == 2'h3), "oc out");
        chk(fl.fet_oc === (m == 2'h3 ? 6'h00 : 6'h01), "oc flag");
        chk({st[4], st[0]} === {2{m != 2'h3}}, "oc status");
        chk(g_hs === (m[1] ? 3'b101 : 3'b000), "oc gates");
        oc_raw = 6'h00;
        cyc(30);
        chk(err_n === (m == 2'h1 || m == 2'h3), "oc recover");
        chk(g_ls === (m == 2'h0 ? 3'b000 : 3'b010), "oc hold");
        chk(fl.overcurrent_flag === (m != 2'h3), "oc sticky");
        clr();
        chk({err_n, fl.overcurrent_flag} === 2'b10, "oc clear");
    endtask
    task pin_variant;
        cfg.hw_variant = 1'b1;
        slew = 1'b1;
        oc_raw = 6'h02;
        cyc(12);
        chk({err_n, lvl} === 3'b101, "pin glitch");
        cyc(12);
        chk({err_n, g_hs} === 4'h0, "pin latch");
        oc_raw = 6'h00;
        cyc(30);
        chk(err_n === 1'b0, "pin hold");
        clr();
        cfg = '0;
    endtask
    task buck_trip;
        bk_raw = 1'b1;
        cyc(34);
        chk({bk, err_n, fl.buck_error_flag, st[6]} === 4'h3, "buck");
        bk_raw = 1'b0;
        cyc(25);
        chk({bk, err_n, fl.buck_overcurrent_flag} === 3'b110, "buck");
    endtask
    task thermal;
        tf_raw = 1'b1;
        cyc(8);
        chk({cp, bk, g_hs, err_n} === 6'h10, "fet tsd");
        tf_raw = 1'b0;
        td_raw = 1'b1;
        cyc(8);
        chk({cp, bk, err_n} === 3'b000, "die tsd");
        td_raw = 1'b0;
        cyc(10);
        chk({cp, bk, err_n, fl.thermal_shutdown_flag} === 4'hf, "tsd");
        clr();
        chk(fl.thermal_shutdown_flag === 1'b0, "tsd clear");
    endtask
    task warning;
        warn_raw = 1'b1;
        cyc(8);
        chk({err_n, fl.temp_warning_flag, st[1]} === 3'b111, "warn");
        cfg.warning_report_en = 1'b1;
        cyc(3);
        chk(err_n === 1'b0, "warn report");
        clr();
        chk(fl.temp_warning_flag === 1'b1, "warn hot");
        warn_raw = 1'b0;
        cyc(8);
        chk(err_n === 1'b1, "warn cool");
        clr();
        chk(fl.temp_warning_flag === 1'b0, "warn clear");
        cfg.warning_report_en = 1'b0;
    endtask
    task disable_pin;
        off_req = 1'b1;
        oc_raw = 6'h3f;
        cyc(16);
        chk({g_hs, g_ls, fl.overcurrent_flag, cp} === 8'h01, "off");
        oc_raw = 6'h00;
        cyc(10);
        off_req = 1'b0;
        cyc(6);
        chk({g_hs, g_ls} === 6'b101010, "on");
    endtask
    task reset_pulse;
        warn_raw = 1'b1;
        cyc(8);
        warn_raw = 1'b0;
        pulse_req = 1'b1;
        cyc(2);
        pulse_req = 1'b0;
        cyc(30);
        chk({fl.temp_warning_flag, cp, se, err_n} === 4'h7, "pulse");
    endtask
    task sleep_wake;
        sleep_req = 1'b1;
        cyc(700);
        chk({err_n, cp} === 2'b01, "entering");
        cyc(3000);
        chk({err_n, cp, bk, av, sa, se, g_hs} === 9'h100, "asleep");
        sleep_req = 1'b0;
        cyc(6);
        chk(err_n === 1'b0, "waking");
        wake();
        sup = 1'b0;
        cyc(6);
        chk({cp, se, g_hs} === 5'h00, "supply low");
        sup = 1'b1;
        cyc(14);
        wake();
    endtask
    initial begin
        cyc(8);
        reset_n = 1'b1;
        wake();
        for (int m = 0; m < 4; m++) oc_mode(2'(m));
        pin_variant();
        buck_trip();
        thermal();
        warning();
        disable_pin();
        reset_pulse();
        sleep_wake();
        report_and_stop();
    end
endmodule
`default_nettype wire
